// ### ats_map.vh
// Holds register map, fields, reset values and bus codes of the skip block.
// Assumes inclusion by bare name from each file.
//
// How it works
// - Mode one: either trigger decrements skip counter
// - Trigger at zero reloads, passes, pulses request
// - No trigger passes and no request unless delaying function enabled
// - Counter equal compare A/B makes trigger
// - Skip setting only matters while mode is one
// - Mode zero clears the skip counter
// - Counter is zero after reset; first trigger fires
// - Counter stopped keeps skip counter value
// - Second independent instance with own settings
// - Skip count is three-bit plain binary
// - Spacing violated may give miscounted requests
// - Mode set to one clears alternate setting
`ifndef ATS_MAP_VH
`define ATS_MAP_VH

// ==========================================================================
// Address decode
// ==========================================================================
`define ATS_ADDR_W      6
`define ATS_INST_BIT    5
`define ATS_REG_MSB     4
`define ATS_REG_LSB     2
`define ATS_REG_CTRL    3'h0
`define ATS_REG_SKIP    3'h1
`define ATS_REG_CMPA    3'h2
`define ATS_REG_CMPB    3'h3
`define ATS_REG_PERIOD  3'h4
`define ATS_REG_ALT     3'h5
`define ATS_REG_STATUS  3'h6

// ==========================================================================
// Fields
// ==========================================================================
`define ATS_CTRL_RUN    0
`define ATS_CTRL_DLY    1
`define ATS_CTRL_MODE   2
`define ATS_CTRL_W      3
`define ATS_SKIP_W      3
`define ATS_ALT_W       8
`define ATS_STAT_SKIP_LSB 16

// ==========================================================================
// Reset values and bus codes
// ==========================================================================
`define ATS_RST_CTRL    3'h0
`define ATS_RST_SKIP    3'h0
`define ATS_RST_ALT     8'h00
`define ATS_RESP_OKAY   2'h0
`define ATS_RESP_SLVERR 2'h2

`endif

// ### ats_trig_gen.v
// Holds one channel counter and its two A/D compare triggers.
// Assumes compare and period values come from registers on the same clock.
`timescale 1ns/1ps
`include "ats_map.vh"

module ats_trig_gen #(
  parameter CNT_W = 16                    // Channel counter width
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             count_run,       // Channel counter enable
  input  wire             delay_en,        // Delaying function enable
  input  wire [CNT_W-1:0] period,          // Wrap value
  input  wire [CNT_W-1:0] adc_compare_a,   // Compare for trigger A
  input  wire [CNT_W-1:0] adc_compare_b,   // Compare for trigger B
  output reg  [CNT_W-1:0] channel_counter, // Current count
  output reg              trig_a,          // One-cycle trigger A
  output reg              trig_b           // One-cycle trigger B
);

  // ========================================================================
  // Channel counter and compares
  // ========================================================================
  // Sawtooth count; a stopped counter makes no match, so triggers cease
  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_counter <= {CNT_W{1'b0}};
      trig_a          <= 1'b0;
      trig_b          <= 1'b0;
    end else begin
      trig_a <= count_run && delay_en && (channel_counter == adc_compare_a);
      trig_b <= count_run && delay_en && (channel_counter == adc_compare_b);
      if (count_run) begin
        if (channel_counter == period) begin
          channel_counter <= {CNT_W{1'b0}};     // Wrap at period
        end else begin
          channel_counter <= channel_counter + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // ats_trig_gen

// ### ats_skip_unit.v
// Holds the down-counting skip counter and the combined request pulse.
// Assumes triggers are one-cycle pulses from logic on the same clock.
`timescale 1ns/1ps
`include "ats_map.vh"

module ats_skip_unit (
  input  wire                  aclk,
  input  wire                  aresetn,
  input  wire                  delay_en,          // Delaying function enable
  input  wire                  skip_mode_select,  // Selects this skip scheme
  input  wire [`ATS_SKIP_W-1:0] skip_count,       // Reload value
  input  wire                  trig_a,            // Trigger A pulse
  input  wire                  trig_b,            // Trigger B pulse
  output reg                   trig_a_valid,      // Passed trigger A
  output reg                   trig_b_valid,      // Passed trigger B
  output reg                   combined_adc_req,  // A-or-B start pulse
  output reg  [`ATS_SKIP_W-1:0] skip_counter      // Counter for readback
);

  // ========================================================================
  // Event qualification
  // ========================================================================
  // Coincident A and B form one event so the count moves once
  wire evt    = delay_en && skip_mode_select && (trig_a || trig_b);
  wire at_zero = (skip_counter == {`ATS_SKIP_W{1'b0}});

  // ========================================================================
  // Skip counter
  // ========================================================================
  // Too-close compares may merge events; software keeps spacing
  always @(posedge aclk) begin
    if (!aresetn) begin
      skip_counter     <= {`ATS_SKIP_W{1'b0}};
      combined_adc_req <= 1'b0;
      trig_a_valid     <= 1'b0;
      trig_b_valid     <= 1'b0;
    end else begin
      combined_adc_req <= 1'b0;
      trig_a_valid     <= 1'b0;
      trig_b_valid     <= 1'b0;
      if (!skip_mode_select) begin
        skip_counter <= {`ATS_SKIP_W{1'b0}};
        // Other scheme: triggers pass unskipped
        trig_a_valid <= delay_en && trig_a;
        trig_b_valid <= delay_en && trig_b;
      end else if (evt) begin
        if (at_zero) begin
          skip_counter     <= skip_count;
          combined_adc_req <= 1'b1;
          trig_a_valid     <= trig_a;
          trig_b_valid     <= trig_b;
        end else begin
          // Nonzero count: trigger is swallowed
          skip_counter <= skip_counter - {{(`ATS_SKIP_W-1){1'b0}}, 1'b1};
        end
      end
      // No event: value retained, also when channel counter stops
    end
  end

endmodule // ats_skip_unit

// ### ats_top.v
// Holds the AXI4-Lite register file and two trigger skip channels.
// Assumes a single master with one write and one read outstanding at most.
`timescale 1ns/1ps
`include "ats_map.vh"

module ats_top #(
  parameter CNT_W = 16                          // Channel counter width
) (
  input  wire                   aclk,
  input  wire                   aresetn,
  // AXI4-Lite write address
  input  wire [`ATS_ADDR_W-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  // AXI4-Lite read address
  input  wire [`ATS_ADDR_W-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  // First channel pair outputs
  output wire                   trig_a_valid_first,
  output wire                   trig_b_valid_first,
  output wire                   combined_adc_req_first,
  // Second channel pair outputs
  output wire                   trig_a_valid_second,
  output wire                   trig_b_valid_second,
  output wire                   combined_adc_req_second
);

  // ========================================================================
  // Byte lane merge
  // ========================================================================
  // Applies write strobes to the current word
  function [31:0] ats_merge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0]  strb;
    integer k;
    begin
      ats_merge = old_w;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          ats_merge[k*8 +: 8] = new_w[k*8 +: 8];
        end
      end
    end
  endfunction

  // ========================================================================
  // Write channel capture
  // ========================================================================
  reg                   aw_held_r;   // Write address taken
  reg                   w_held_r;    // Write data taken
  reg [`ATS_ADDR_W-1:0] aw_addr_r;   // Captured write address
  reg [31:0]            w_data_r;    // Captured write data
  reg [3:0]             w_strb_r;    // Captured strobes

  // Refused while its own word waits or a response hangs
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;

  // Write performed once both halves are held
  wire wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  wire [2:0] wr_reg = aw_addr_r[`ATS_REG_MSB:`ATS_REG_LSB];
  wire wr_ok = (wr_reg <= `ATS_REG_STATUS);

  // Captures address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= {`ATS_ADDR_W{1'b0}};
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Write response
  // ========================================================================
  // Unmapped slot answers SLVERR; writes to status are dropped with OKAY
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ATS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `ATS_RESP_OKAY : `ATS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ========================================================================
  // Two channel pairs
  // ========================================================================
  wire [63:0] rd_flat;   // Read words of both instances, second in top half
  wire [1:0]  a_valid;   // Passed A per instance
  wire [1:0]  b_valid;   // Passed B per instance
  wire [1:0]  comb_req;  // Combined request per instance

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_inst
      reg [`ATS_CTRL_W-1:0] ctrl_r;      // Run, delay enable, mode
      reg [`ATS_SKIP_W-1:0] skip_set_r;  // Skip count setting
      reg [CNT_W-1:0]       cmp_a_r;     // Compare A
      reg [CNT_W-1:0]       cmp_b_r;     // Compare B
      reg [CNT_W-1:0]       period_r;    // Counter wrap value
      reg [`ATS_ALT_W-1:0]  alt_set_r;   // Alternate scheme setting
      wire [CNT_W-1:0]      cnt;         // Channel counter
      wire [`ATS_SKIP_W-1:0] skip_cnt;   // Skip counter
      wire                  ta;          // Trigger A
      wire                  tb;          // Trigger B
      wire [31:0]           merged;      // Strobed write value
      reg  [31:0]           cur;         // Current value of target register

      wire sel_w = wr_fire && (aw_addr_r[`ATS_INST_BIT] == (gi == 1));

      // Current value for byte lane merge
      always @* begin
        cur = 32'h0000_0000;
        case (wr_reg)
          `ATS_REG_CTRL:   cur[`ATS_CTRL_W-1:0] = ctrl_r;
          `ATS_REG_SKIP:   cur[`ATS_SKIP_W-1:0] = skip_set_r;
          `ATS_REG_CMPA:   cur[CNT_W-1:0]       = cmp_a_r;
          `ATS_REG_CMPB:   cur[CNT_W-1:0]       = cmp_b_r;
          `ATS_REG_PERIOD: cur[CNT_W-1:0]       = period_r;
          `ATS_REG_ALT:    cur[`ATS_ALT_W-1:0]  = alt_set_r;
          default:         cur = 32'h0000_0000;
        endcase
      end
      assign merged = ats_merge(cur, w_data_r, w_strb_r);

      // Register writes
      always @(posedge aclk) begin
        if (!aresetn) begin
          ctrl_r     <= `ATS_RST_CTRL;
          skip_set_r <= `ATS_RST_SKIP;
          cmp_a_r    <= {CNT_W{1'b0}};
          cmp_b_r    <= {CNT_W{1'b0}};
          period_r   <= {CNT_W{1'b1}};
          alt_set_r  <= `ATS_RST_ALT;
        end else if (sel_w) begin
          case (wr_reg)
            `ATS_REG_CTRL: begin
              ctrl_r <= merged[`ATS_CTRL_W-1:0];
              if (merged[`ATS_CTRL_MODE]) begin
                alt_set_r <= `ATS_RST_ALT;
              end
            end
            `ATS_REG_SKIP:   skip_set_r <= merged[`ATS_SKIP_W-1:0];
            `ATS_REG_CMPA:   cmp_a_r    <= merged[CNT_W-1:0];
            `ATS_REG_CMPB:   cmp_b_r    <= merged[CNT_W-1:0];
            `ATS_REG_PERIOD: period_r   <= merged[CNT_W-1:0];
            `ATS_REG_ALT: begin
              // Alternate setting is frozen at zero while this scheme runs
              if (!ctrl_r[`ATS_CTRL_MODE]) begin
                alt_set_r <= merged[`ATS_ALT_W-1:0];
              end
            end
            default: begin
              // Status and unmapped: nothing stored
            end
          endcase
        end
      end

      // Counter and compare triggers
      ats_trig_gen #(
        .CNT_W(CNT_W)
      ) u_trig (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .count_run       (ctrl_r[`ATS_CTRL_RUN]),
        .delay_en        (ctrl_r[`ATS_CTRL_DLY]),
        .period          (period_r),
        .adc_compare_a   (cmp_a_r),
        .adc_compare_b   (cmp_b_r),
        .channel_counter (cnt),
        .trig_a          (ta),
        .trig_b          (tb)
      );

      // Skip counter and combined request
      ats_skip_unit u_skip (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .delay_en         (ctrl_r[`ATS_CTRL_DLY]),
        .skip_mode_select (ctrl_r[`ATS_CTRL_MODE]),
        .skip_count       (skip_set_r),
        .trig_a           (ta),
        .trig_b           (tb),
        .trig_a_valid     (a_valid[gi]),
        .trig_b_valid     (b_valid[gi]),
        .combined_adc_req (comb_req[gi]),
        .skip_counter     (skip_cnt)
      );

      // Read word of this instance for the selected register
      reg [31:0] rword;
      always @* begin
        rword = 32'h0000_0000;
        case (s_axi_araddr[`ATS_REG_MSB:`ATS_REG_LSB])
          `ATS_REG_CTRL:   rword[`ATS_CTRL_W-1:0] = ctrl_r;
          `ATS_REG_SKIP:   rword[`ATS_SKIP_W-1:0] = skip_set_r;
          `ATS_REG_CMPA:   rword[CNT_W-1:0]       = cmp_a_r;
          `ATS_REG_CMPB:   rword[CNT_W-1:0]       = cmp_b_r;
          `ATS_REG_PERIOD: rword[CNT_W-1:0]       = period_r;
          `ATS_REG_ALT:    rword[`ATS_ALT_W-1:0]  = alt_set_r;
          `ATS_REG_STATUS: begin
            rword[CNT_W-1:0] = cnt;
            rword[`ATS_STAT_SKIP_LSB +: `ATS_SKIP_W] = skip_cnt;
          end
          default:         rword = 32'h0000_0000;
        endcase
      end
      assign rd_flat[gi*32 +: 32] = rword;
    end
  endgenerate

  assign trig_a_valid_first      = a_valid[0];
  assign trig_b_valid_first      = b_valid[0];
  assign combined_adc_req_first  = comb_req[0];
  assign trig_a_valid_second     = a_valid[1];
  assign trig_b_valid_second     = b_valid[1];
  assign combined_adc_req_second = comb_req[1];

  // ========================================================================
  // Read channel
  // ========================================================================
  // One read in flight; address refused while the data waits
  assign s_axi_arready = !s_axi_rvalid;

  wire [2:0] rd_reg = s_axi_araddr[`ATS_REG_MSB:`ATS_REG_LSB];
  wire rd_ok = (rd_reg <= `ATS_REG_STATUS);

  // Data captured at address handshake, so it holds while waiting
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `ATS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rd_ok ? `ATS_RESP_OKAY : `ATS_RESP_SLVERR;
      if (s_axi_araddr[`ATS_INST_BIT]) begin
        s_axi_rdata <= rd_flat[63:32];
      end else begin
        s_axi_rdata <= rd_flat[31:0];
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ats_top

// ### ats_props.sv
// Port checker for the trigger skip block: bus answers and output pulses.
// Assumes it is bound to ats_top with one clock and active-low reset.
`timescale 1ns/1ps
`include "ats_map.vh"
module ats_props (
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        trig_a_valid_first,
  input logic        trig_b_valid_first,
  input logic        combined_adc_req_first,
  input logic        trig_a_valid_second,
  input logic        trig_b_valid_second,
  input logic        combined_adc_req_second
);
  // ==========================================
  // Sequences
  // ==========================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Request line stays low for the legal trigger spacing
  sequence s_quiet;
    !combined_adc_req_first [*3];
  endsequence
  // Write answer lands two edges after both halves are taken
  sequence s_bresp;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  // ==========================================
  // Assertions
  // ==========================================
  AST_REQ_PULSE: assert property (combined_adc_req_first |=> s_quiet)
    else $error("start request not a single pulse");
  AST_REQ_TRIG_FIRST: assert property (
    combined_adc_req_first |-> (trig_a_valid_first || trig_b_valid_first))
    else $error("start request without passed trigger");
  AST_REQ_TRIG_SECOND: assert property (
    combined_adc_req_second |-> (trig_a_valid_second || trig_b_valid_second))
    else $error("second start request without passed trigger");
  AST_PASS_PULSE: assert property (trig_a_valid_first |=> !trig_a_valid_first)
    else $error("passed trigger longer than one cycle");
  AST_B_TIMING: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_bresp)
    else $error("write answer late or early");
  AST_R_TIMING: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
endmodule // ats_props

bind ats_top ats_props u_props (.*);

// ### ats_adc_model.sv
// Converter start-input model: logs each start pulse and passed trigger.
// Assumes one-cycle pulses launched from the rising clock edge.
`timescale 1ns/1ps
module ats_adc_model (
  input logic aclk,
  input logic aresetn,
  input logic req_first,
  input logic a_first,
  input logic b_first,
  input logic req_second,
  input logic a_second,
  input logic b_second
);
  // ==========================================
  // Logs
  // ==========================================
  int cyc = 0;           // Cycle stamp
  int st1[$], st2[$];    // Start stamps per pair
  int na1 = 0, nb1 = 0;  // Passed A and B, first pair
  int na2 = 0, nb2 = 0;  // Passed A and B, second pair
  // Each high sample is one start; a longer pulse counts once per high cycle
  always @(posedge aclk) begin
    cyc++;
    if (aresetn) begin
      if (req_first) st1.push_back(cyc);
      if (req_second) st2.push_back(cyc);
      if (a_first) na1++;
      if (b_first) nb1++;
      if (a_second) na2++;
      if (b_second) nb2++;
    end
  end
  // Call between edges, so no update is lost
  task automatic clear;
    st1.delete();
    st2.delete();
    {na1, nb1, na2, nb2} = 128'h0;
  endtask
endmodule // ats_adc_model

// ### adc_trigger_skip_counter_bench.sv
// Self-checking bench for the trigger skip block over AXI4-Lite.
// Assumes period 15, compares 2 and 8: triggers 6 and 10 cycles apart.
`timescale 1ns/1ps
`include "ats_map.vh"
module adc_trigger_skip_counter_bench;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0;
  logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  wire         awready, wready, bvalid, arready, rvalid, af, bf, rf, as, bs, rs;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  int          mismatches = 0, checks = 0, cycles = 0;

  ats_top #(.CNT_W(16)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .trig_a_valid_first(af), .trig_b_valid_first(bf),
    .combined_adc_req_first(rf), .trig_a_valid_second(as),
    .trig_b_valid_second(bs), .combined_adc_req_second(rs));
  ats_adc_model u_adc (.aclk(aclk), .aresetn(aresetn), .req_first(rf), .a_first(af),
    .b_first(bf), .req_second(rs), .a_second(as), .b_second(bs));

  // ==========================================
  // Clock, timeout, verdict
  // ==========================================
  initial begin
    forever #5 aclk = ~aclk;
  end
  // Run needs about 450 cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      final_report;
    end
  end
  task automatic final_report;
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================
  // Compare and bus tasks
  // ==========================================
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp, input string what);
    checks++;
    if (got != exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask
  function automatic logic [5:0] ra(input logic i, input logic [2:0] r);
    return {i, r, 2'b00};
  endfunction
  // Halves offered at once, each dropped when taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    {aw_ok, w_ok} = 2'b00;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'b111;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      aw_ok = aw_ok || awready;
      w_ok = w_ok || wready;
      if (aw_ok) awvalid <= 0;
      if (w_ok) wvalid <= 0;
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk_reg({30'h0, r}, 32'h0, "write resp");
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk_reg(d, exp, what);
  endtask
  // Fresh logs, then four counter periods
  task automatic watch;
    @(negedge aclk);
    u_adc.clear();
    repeat (64) @(negedge aclk);
  endtask

  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_reset_values;
    logic [31:0] d;
    logic [1:0] r;
    rchk(ra(1'b0, `ATS_REG_CTRL), 32'h0, "ctrl reset");
    rchk(ra(1'b0, `ATS_REG_SKIP), 32'h0, "skip reset");
    rchk(ra(1'b1, `ATS_REG_PERIOD), 32'h0000ffff, "period reset");
    rchk(ra(1'b0, `ATS_REG_STATUS), 32'h0, "counter reset");
    rd(6'h1c, d, r);
    chk_reg({30'h0, r}, {30'h0, `ATS_RESP_SLVERR}, "unmapped read");
    wr(6'h3c, 32'h7, r);
    chk_reg({30'h0, r}, {30'h0, `ATS_RESP_SLVERR}, "unmapped write");
  endtask
  // Compares 6 apart and set once, legal for any skip count
  task automatic t_setup;
    for (int i = 0; i < 2; i++) begin
      wreg(ra(i[0], `ATS_REG_PERIOD), 32'h0000000f);
      wreg(ra(i[0], `ATS_REG_CMPA), 32'h00000002);
      wreg(ra(i[0], `ATS_REG_CMPB), 32'h00000008);
    end
    wreg(ra(1'b0, `ATS_REG_SKIP), 32'h00000004);
    wreg(ra(1'b1, `ATS_REG_SKIP), 32'h00000001);
  endtask
  // Fresh zero counter: trigger 0 fires, then every fifth (A, B, A)
  task automatic t_skip_four;
    @(negedge aclk);
    u_adc.clear();
    wreg(ra(1'b0, `ATS_REG_CTRL), 32'h00000007);
    while (u_adc.st1.size() < 3) @(negedge aclk);
    chk_cnt(u_adc.st1[1] - u_adc.st1[0], 38, "first skip gap");
    chk_cnt(u_adc.st1[2] - u_adc.st1[1], 42, "second skip gap");
    chk_cnt(u_adc.na1, 2, "passed a");
    chk_cnt(u_adc.nb1, 1, "passed b");
  endtask
  // Stop just after a reload, so the held count is not zero
  task automatic t_stop_retain;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = u_adc.st1.size();
    while (u_adc.st1.size() == n) @(negedge aclk);
    wreg(ra(1'b0, `ATS_REG_CTRL), 32'h00000006);
    rd(ra(1'b0, `ATS_REG_STATUS), d, r);
    chk_reg({29'h0, d[18:16]}, 32'h4, "count held");
    repeat (40) @(posedge aclk);
    rchk(ra(1'b0, `ATS_REG_STATUS), d, "status after stop");
  endtask
  // Mode zero: counter cleared, triggers pass unskipped, no start
  task automatic t_mode_zero;
    logic [31:0] d;
    logic [1:0] r;
    wreg(ra(1'b0, `ATS_REG_CTRL), 32'h00000003);
    rd(ra(1'b0, `ATS_REG_STATUS), d, r);
    chk_reg({29'h0, d[18:16]}, 32'h0, "counter cleared");
    watch;
    chk_cnt(u_adc.na1, 4, "a unskipped");
    chk_cnt(u_adc.nb1, 4, "b unskipped");
    chk_cnt(u_adc.st1.size(), 0, "no start in mode zero");
  endtask
  // Mode one clears alt setting; delay off blocks all
  task automatic t_alt_delay;
    wreg(ra(1'b0, `ATS_REG_ALT), 32'h000000a5);
    rchk(ra(1'b0, `ATS_REG_ALT), 32'h000000a5, "alt kept");
    wreg(ra(1'b0, `ATS_REG_CTRL), 32'h00000005);
    rchk(ra(1'b0, `ATS_REG_ALT), 32'h0, "alt cleared");
    watch;
    chk_cnt(u_adc.na1 + u_adc.nb1 + u_adc.st1.size(), 0, "delay off");
  endtask
  // Second pair, skip one: every other trigger, all A
  task automatic t_second;
    @(negedge aclk);
    u_adc.clear();
    wreg(ra(1'b1, `ATS_REG_CTRL), 32'h00000007);
    while (u_adc.st2.size() < 3) @(negedge aclk);
    chk_cnt(u_adc.st2[1] - u_adc.st2[0], 16, "second gap one");
    chk_cnt(u_adc.st2[2] - u_adc.st2[1], 16, "second gap two");
    chk_cnt(u_adc.na2, 3, "second passed a");
    chk_cnt(u_adc.nb2, 0, "second passed b");
    chk_cnt(u_adc.st1.size(), 0, "first pair silent");
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    t_reset_values;
    t_setup;
    t_skip_four;
    t_stop_retain;
    t_mode_zero;
    t_alt_delay;
    t_second;
    final_report;
  end
endmodule // adc_trigger_skip_counter_bench
